// >>> rtl/bit_sync.sv
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // first stage is read only by the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule // bit_sync

// >>> rtl/tick_divider.sv
// divider that emits a one-cycle enable pulse every CYCLES clocks
`timescale 1ns/1ps
module tick_divider #(
  parameter int CYCLES = 50000
) (
  input wire logic hclk,
  input wire logic hresetn,
  output logic tick
);
  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    nxt_tick = (cnt_ff == LAST);
    nxt_cnt = nxt_tick ? '0 : cnt_ff + CW'(1);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule // tick_divider

// >>> rtl/usb_attach_detach_control.sv
// usb attach/detach control: pull-up, vbus sense, out-of-band detach and wake, ahb-lite registers
//
// Operation
// RQ1: the port is full speed only, announced by a pull-up on the positive line, with no external transceiver logic.
// RQ2: the block only answers the host and never starts traffic; the host is bus master.
// RQ3: the positive line pull-up is enabled only once software marks the device ready to enumerate.
// RQ4: the pull-up is internal by default or driven from a selectable general purpose pin.
// RQ5: in self-powered mode the pull-up stays off whenever the bus-power sense input is low.
// RQ6: the bus-power sense input comes from general purpose pin two by default.
// RQ7: a high detach request floats both data lines and removes the pull-up.
// RQ8: when the detach request falls the pull-up is restored and the device waits for enumeration.
// RQ9: the active-high host wake output is used only while the detach request is high.
// RQ10: while detached no in-band resume is driven on the data lines; the wake pin is used instead.
// RQ11: detach and wake may each be mapped to any general purpose pin.
// RQ12: in bus-powered mode the power figure for enumeration is held in a register; the mode is off at reset.
// RQ13: on bus power the block enters a suspended low-power state after bus idle.
// RQ14: detach and bus-power sense are synchronised before use.
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module usb_attach_detach_control #(
  parameter int TICK_CYCLES = usb_attach_pkg::MS_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [usb_attach_pkg::PIN_COUNT-1:0] general_purpose_pin_in,
  output logic [usb_attach_pkg::PIN_COUNT-1:0] general_purpose_pin_out,
  output logic [usb_attach_pkg::PIN_COUNT-1:0] general_purpose_pin_oe,
  input wire logic data_plus_line_in,
  output logic data_plus_line_out,
  output logic data_plus_line_oe,
  input wire logic data_minus_line_in,
  output logic data_minus_line_out,
  output logic data_minus_line_oe,
  output logic dp_pullup_en,
  output logic low_power
);
  localparam int PC = usb_attach_pkg::PIN_COUNT;

  // ----------------------------------------------------------------
  // input synchronisation and timebase
  // ----------------------------------------------------------------
  logic [PC-1:0] pins_s;
  logic dp_s;
  logic dm_s;
  logic tick;

  // RQ14 sync pin inputs
  bit_sync #(.WIDTH(PC + 2)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({data_minus_line_in, data_plus_line_in, general_purpose_pin_in}),
    .sync_out({dm_s, dp_s, pins_s})
  );

  tick_divider #(.CYCLES(TICK_CYCLES)) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  usb_attach_pkg::ctrl_t ctrl_ff;
  usb_attach_pkg::ctrl_t nxt_ctrl;
  usb_attach_pkg::pinsel_t pinsel_ff;
  usb_attach_pkg::pinsel_t nxt_pinsel;
  logic [7:0] power_ff;
  logic [7:0] nxt_power;
  logic wr_pend_ff;
  logic nxt_wr_pend;
  logic [3:0] wr_addr_ff;
  logic [3:0] nxt_wr_addr;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic wake_cmd_ff;
  logic nxt_wake_cmd;
  usb_attach_pkg::status_t status;

  // ----------------------------------------------------------------
  // link state
  // ----------------------------------------------------------------
  usb_attach_pkg::link_state_t state_ff;
  usb_attach_pkg::link_state_t nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [3:0] wake_cnt_ff;
  logic [3:0] nxt_wake_cnt;
  logic pull_on_ff;
  logic nxt_pull_on;
  logic pullup_int_ff;
  logic nxt_pullup_int;
  logic line_oe_ff;
  logic nxt_line_oe;
  logic low_power_ff;
  logic nxt_low_power;
  logic [PC-1:0] gp_out_ff;
  logic [PC-1:0] nxt_gp_out;
  logic [PC-1:0] gp_oe_ff;
  logic [PC-1:0] nxt_gp_oe;

  logic vbus;
  logic detach;
  logic power_ok;
  logic attach_ok;
  logic bus_idle;
  logic access;

  // RQ6 vbus sense pin mapping
  assign vbus = usb_attach_pkg::pick_pin(pins_s, pinsel_ff.vbus_pin);
  // RQ11 detach pin mapping
  assign detach = usb_attach_pkg::pick_pin(pins_s, pinsel_ff.detach_pin);
  // RQ5 vbus gates pull-up
  assign power_ok = !ctrl_ff.self_powered || vbus;
  // RQ3 ready gates attach
  assign attach_ok = ctrl_ff.ready && !detach && power_ok;
  // full-speed idle is J: plus high, minus low
  assign bus_idle = dp_s && !dm_s;
  assign access = hsel && hready && htrans[1];

  assign status = '{state: state_ff, resume: state_ff == usb_attach_pkg::ST_RESUME,
                    suspended: state_ff == usb_attach_pkg::ST_SUSPENDED,
                    wake_active: wake_cnt_ff != 4'h0, pull_on: pull_on_ff, detached: detach, vbus: vbus};

  // ----------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_pinsel = pinsel_ff;
    nxt_power = power_ff;
    nxt_wake_cmd = 1'b0;
    nxt_wr_pend = access && hwrite && (hsize == usb_attach_pkg::HSIZE_WORD);
    nxt_wr_addr = haddr[3:0];
    nxt_rdata = rdata_ff;
    if (access && !hwrite) begin
      case (haddr[3:0])
        usb_attach_pkg::CTRL_OFF: nxt_rdata = {28'h0000000, ctrl_ff};
        usb_attach_pkg::PINSEL_OFF: nxt_rdata = {16'h0000, pinsel_ff};
        usb_attach_pkg::POWER_OFF: nxt_rdata = {24'h000000, power_ff};
        usb_attach_pkg::STATUS_OFF: nxt_rdata = {24'h000000, status};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
    if (wr_pend_ff && hready) begin
      case (wr_addr_ff)
        usb_attach_pkg::CTRL_OFF: begin
          nxt_ctrl = hwdata[3:0];
          // wake request is a command, never stored
          nxt_ctrl.wake_req = 1'b0;
          nxt_wake_cmd = hwdata[3];
        end
        // RQ11 software pin map
        usb_attach_pkg::PINSEL_OFF: nxt_pinsel = hwdata[15:0];
        // RQ12 power figure
        usb_attach_pkg::POWER_OFF: nxt_power = hwdata[7:0];
        default: nxt_wake_cmd = 1'b0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= usb_attach_pkg::CTRL_RST;
      pinsel_ff <= usb_attach_pkg::PINSEL_RST;
      power_ff <= usb_attach_pkg::POWER_RST;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 4'h0;
      rdata_ff <= 32'h00000000;
      wake_cmd_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      pinsel_ff <= nxt_pinsel;
      power_ff <= nxt_power;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      rdata_ff <= nxt_rdata;
      wake_cmd_ff <= nxt_wake_cmd;
    end
  end

  // ----------------------------------------------------------------
  // attach state machine and pin drive
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    if (!attach_ok) begin
      // RQ7 detach forces off
      nxt_state = usb_attach_pkg::ST_DETACHED;
      nxt_cnt = 4'h0;
    end else begin
      case (state_ff)
        // RQ8 reattach and await host
        usb_attach_pkg::ST_DETACHED: begin
          nxt_state = usb_attach_pkg::ST_ATTACHED;
          nxt_cnt = 4'h0;
        end
        // RQ13 idle leads to suspend
        usb_attach_pkg::ST_ATTACHED: begin
          if (!bus_idle) begin
            nxt_cnt = 4'h0;
          end else if (tick) begin
            if (cnt_ff == usb_attach_pkg::SUSPEND_IDLE_MS - 4'h1) begin
              nxt_state = usb_attach_pkg::ST_SUSPENDED;
              nxt_cnt = 4'h0;
            end else begin
              nxt_cnt = cnt_ff + 4'h1;
            end
          end
        end
        // RQ2 leave suspend only on host traffic, resume, or loss of attach (detach, not ready, or no vbus when self-powered)
        usb_attach_pkg::ST_SUSPENDED: begin
          if (wake_cmd_ff) begin
            nxt_state = usb_attach_pkg::ST_RESUME;
            nxt_cnt = 4'h0;
          end else if (!bus_idle) begin
            nxt_state = usb_attach_pkg::ST_ATTACHED;
          end
        end
        usb_attach_pkg::ST_RESUME: begin
          if (tick) begin
            if (cnt_ff == usb_attach_pkg::RESUME_DRIVE_MS - 4'h1) begin
              nxt_state = usb_attach_pkg::ST_ATTACHED;
              nxt_cnt = 4'h0;
            end else begin
              nxt_cnt = cnt_ff + 4'h1;
            end
          end
        end
        default: begin
          nxt_state = usb_attach_pkg::ST_DETACHED;
          nxt_cnt = 4'h0;
        end
      endcase
    end

    // RQ9 wake pulse only while detached
    if (!detach) begin
      nxt_wake_cnt = 4'h0;
    end else if (wake_cmd_ff) begin
      nxt_wake_cnt = usb_attach_pkg::WAKE_PULSE_MS;
    end else if (tick && wake_cnt_ff != 4'h0) begin
      nxt_wake_cnt = wake_cnt_ff - 4'h1;
    end else begin
      nxt_wake_cnt = wake_cnt_ff;
    end

    // RQ1 pull-up on plus line marks full speed
    nxt_pull_on = nxt_state != usb_attach_pkg::ST_DETACHED;
    // RQ4 internal or external pull-up
    nxt_pullup_int = nxt_pull_on && !ctrl_ff.ext_pullup;
    // RQ10 in-band resume only when attached
    nxt_line_oe = nxt_state == usb_attach_pkg::ST_RESUME;
    nxt_low_power = (nxt_state == usb_attach_pkg::ST_SUSPENDED) && !ctrl_ff.self_powered;

    // wake pin is driven while detach is high, pull-up pin while the external pull-up is on; others are released
    nxt_gp_out = '0;
    nxt_gp_oe = '0;
    nxt_gp_out[pinsel_ff.wake_pin] = nxt_wake_cnt != 4'h0;
    nxt_gp_oe[pinsel_ff.wake_pin] = detach;
    if (nxt_pull_on && ctrl_ff.ext_pullup) begin
      nxt_gp_out[pinsel_ff.pullup_pin] = 1'b1;
      nxt_gp_oe[pinsel_ff.pullup_pin] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= usb_attach_pkg::ST_DETACHED;
      cnt_ff <= 4'h0;
      wake_cnt_ff <= 4'h0;
      pull_on_ff <= 1'b0;
      pullup_int_ff <= 1'b0;
      line_oe_ff <= 1'b0;
      low_power_ff <= 1'b0;
      gp_out_ff <= '0;
      gp_oe_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      wake_cnt_ff <= nxt_wake_cnt;
      pull_on_ff <= nxt_pull_on;
      pullup_int_ff <= nxt_pullup_int;
      line_oe_ff <= nxt_line_oe;
      low_power_ff <= nxt_low_power;
      gp_out_ff <= nxt_gp_out;
      gp_oe_ff <= nxt_gp_oe;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;
  assign general_purpose_pin_out = gp_out_ff;
  assign general_purpose_pin_oe = gp_oe_ff;
  // resume drives K: plus low, minus high
  assign data_plus_line_out = 1'b0;
  assign data_minus_line_out = line_oe_ff;
  assign data_plus_line_oe = line_oe_ff;
  assign data_minus_line_oe = line_oe_ff;
  assign dp_pullup_en = pullup_int_ff;
  assign low_power = low_power_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_detach_floats: assert property (detach |=> !pull_on_ff && !line_oe_ff && !dp_pullup_en) // RQ7
    else $error("detach did not float lines");
  chk_ready_gate: assert property (!ctrl_ff.ready |=> !pull_on_ff) // RQ3
    else $error("pull-up on before ready");
  chk_vbus_gate: assert property (ctrl_ff.self_powered && !vbus |=> !pull_on_ff) // RQ5
    else $error("pull-up on without vbus");
  chk_reattach_pull: assert property (attach_ok |=> pull_on_ff) // RQ8
    else $error("pull-up not restored");
  chk_pull_select: assert property (##1 dp_pullup_en == (pull_on_ff && !$past(ctrl_ff.ext_pullup))) // RQ4
    else $error("pull-up source wrong");
  chk_wake_detached: assert property (wake_cnt_ff != 4'h0 |-> $past(detach)) // RQ9
    else $error("wake outside detach");
  chk_no_inband: assert property (line_oe_ff |-> $past(attach_ok) && !$past(detach)) // RQ10
    else $error("in-band drive while detached");
  chk_wake_start: assert property (detach && wake_cmd_ff |=> wake_cnt_ff == usb_attach_pkg::WAKE_PULSE_MS) // RQ9
    else $error("wake pulse length wrong");
  chk_low_power: assert property (low_power_ff |-> !$past(ctrl_ff.self_powered)) // RQ13
    else $error("suspend while self powered");

  cov_reattach: cover property (detach ##1 !detach [*2] ##1 pull_on_ff);
  cov_wake: cover property (detach && wake_cmd_ff ##1 wake_cnt_ff != 4'h0);
  cov_suspend: cover property (state_ff == usb_attach_pkg::ST_SUSPENDED ##1 state_ff == usb_attach_pkg::ST_RESUME);
endmodule // usb_attach_detach_control

// >>> rtl/usb_attach_pkg.sv
// package: constants, register layout and types for the usb attach/detach control block
package usb_attach_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] PINSEL_OFF = 4'h4;
  localparam logic [3:0] POWER_OFF = 4'h8;
  localparam logic [3:0] STATUS_OFF = 4'hC;

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam int PIN_COUNT = 16;
  localparam int PIN_IDX_W = 4;

  typedef struct packed {
    logic wake_req;
    logic self_powered;
    logic ext_pullup;
    logic ready;
  } ctrl_t;

  typedef struct packed {
    logic [PIN_IDX_W-1:0] pullup_pin;
    logic [PIN_IDX_W-1:0] wake_pin;
    logic [PIN_IDX_W-1:0] detach_pin;
    logic [PIN_IDX_W-1:0] vbus_pin;
  } pinsel_t;

  typedef struct packed {
    logic [1:0] state;
    logic resume;
    logic suspended;
    logic wake_active;
    logic pull_on;
    logic detached;
    logic vbus;
  } status_t;

  localparam ctrl_t CTRL_RST = 4'h4;
  localparam pinsel_t PINSEL_RST = 16'h5432;
  localparam logic [7:0] POWER_RST = 8'h32;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [3:0] SUSPEND_IDLE_MS = 4'h3;
  localparam logic [3:0] RESUME_DRIVE_MS = 4'hA;
  localparam logic [3:0] WAKE_PULSE_MS = 4'hA;

  typedef enum logic [1:0] {
    ST_DETACHED = 2'b00,
    ST_ATTACHED = 2'b01,
    ST_SUSPENDED = 2'b10,
    ST_RESUME = 2'b11
  } link_state_t;

  function automatic logic pick_pin(input logic [PIN_COUNT-1:0] vec, input logic [PIN_IDX_W-1:0] idx);
    pick_pin = vec[idx];
  endfunction

endpackage

// >>> tb/usb_attach_detach_control_test.sv
// self-checking bench for the usb attach/detach control block
`timescale 1ns/1ps
module usb_attach_detach_control_test;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [3:0] A_CTRL = usb_attach_pkg::CTRL_OFF;
  localparam logic [3:0] A_PSEL = usb_attach_pkg::PINSEL_OFF;
  localparam logic [3:0] A_PWR = usb_attach_pkg::POWER_OFF;
  localparam logic [3:0] A_STAT = usb_attach_pkg::STATUS_OFF;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, traffic;
  logic plus_in, plus_out, plus_oe, minus_in, minus_out, minus_oe, pull_en, low_power;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [1:0] htrans;
  logic [2:0] hsize, size_sel;
  logic [15:0] pin_in, pin_out, pin_oe, pin_drv;
  logic [3:0] d, wk;
  int err_count, n_tests;
  assign hready = hreadyout;
  // pins driven by the design win over the bench's level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_drv);
  usb_attach_detach_control #(.TICK_CYCLES(8)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .general_purpose_pin_in(pin_in),
    .general_purpose_pin_out(pin_out), .general_purpose_pin_oe(pin_oe), .data_plus_line_in(plus_in),
    .data_plus_line_out(plus_out), .data_plus_line_oe(plus_oe), .data_minus_line_in(minus_in),
    .data_minus_line_out(minus_out), .data_minus_line_oe(minus_oe), .dp_pullup_en(pull_en),
    .low_power(low_power));
  usb_host_model host (.hclk(hclk), .pull_up(pull_en | (pin_oe[5] & pin_out[5])), .traffic(traffic),
    .plus_out(plus_out), .plus_oe(plus_oe), .minus_out(minus_out), .minus_oe(minus_oe),
    .plus_line(plus_in), .minus_line(minus_in));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    hclk = 1'h0;
    forever #10 hclk = ~hclk;
  end
  function automatic logic [31:0] cw(input logic r, input logic e, input logic s, input logic w);
    cw = {28'h0000000, w, s, e, r};
  endfunction
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask
  // holds each phase until hready is seen high, read data taken at the data phase edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {28'h0000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= size_sel;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] wd);
    bus(1'h1, a, wd);
  endtask
  task automatic rc(input string name, input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'h0, a, 32'h00000000);
    check(name, exp, rd & m);
    check("hresp_okay", 32'h0, hresp);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // a full run needs about 600 cycles
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    summarize();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, traffic} = 4'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = usb_attach_pkg::HSIZE_WORD;
    size_sel = usb_attach_pkg::HSIZE_WORD;
    pin_drv = 16'h0000;
    void'($urandom(32'h4BA3BE14));
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    w(1);
    check("pullup_reset", 32'h0, pull_en);
    rc("ctrl_reset", A_CTRL, 32'hF, 32'(usb_attach_pkg::CTRL_RST));
    rc("pinsel_reset", A_PSEL, 32'hFFFF, 32'(usb_attach_pkg::PINSEL_RST));
    rc("power_reset", A_PWR, 32'hFF, 32'(usb_attach_pkg::POWER_RST));
    size_sel = 3'h0;
    wr(A_CTRL, cw(1'h1, 1'h0, 1'h1, 1'h0));
    size_sel = usb_attach_pkg::HSIZE_WORD;
    rc("ctrl_byte_write", A_CTRL, 32'hF, 32'(usb_attach_pkg::CTRL_RST));
    $display("reset test done");
    @(posedge hclk) traffic <= 1'h1;
    wr(A_CTRL, cw(1'h1, 1'h0, 1'h1, 1'h0));
    w(4);
    check("pullup_no_vbus", 32'h0, pull_en);
    @(posedge hclk) pin_drv[2] <= 1'h1;
    w(1);
    check("pullup_sync", 32'h0, pull_en);
    w(3);
    check("pullup_vbus", 32'h1, pull_en);
    rc("status_attached", A_STAT, 32'hFF, 32'h45);
    @(posedge hclk) pin_drv[2] <= 1'h0;
    wr(A_CTRL, cw(1'h1, 1'h0, 1'h0, 1'h0));
    w(4);
    check("pullup_bus_powered", 32'h1, pull_en);
    @(posedge hclk) pin_drv[2] <= 1'h1;
    $display("vbus test done");
    for (int i = 0; i < 2; i++) begin
      d = 4'($urandom_range(15, 6));
      do wk = 4'($urandom_range(15, 6)); while (wk == d);
      wr(A_PSEL, {16'h0000, 4'h5, wk, d, 4'h2});
      rc("pinsel", A_PSEL, 32'hFFFF, {16'h0000, 4'h5, wk, d, 4'h2});
      wr(A_CTRL, cw(1'h1, 1'h0, 1'h1, 1'h0));
      wr(A_CTRL, cw(1'h1, 1'h0, 1'h1, 1'h1));
      w(4);
      check("wake_refused", 32'h0, {pin_out[wk], plus_oe});
      @(posedge hclk) pin_drv[d] <= 1'h1;
      w(4);
      check("detach_lines", 32'h0, {pull_en, plus_oe, minus_oe});
      check("wake_pin_idle", 32'h2, {pin_oe[wk], pin_out[wk]});
      wr(A_CTRL, cw(1'h1, 1'h0, 1'h1, 1'h1));
      w(60);
      check("wake_pin_high", 32'h1, pin_out[wk]);
      check("no_inband_wake", 32'h0, {plus_oe, minus_oe});
      w(30);
      check("wake_pin_ended", 32'h0, pin_out[wk]);
      wr(A_CTRL, cw(1'h1, 1'h0, 1'h1, 1'h1));
      w(5);
      @(posedge hclk) pin_drv[d] <= 1'h0;
      w(4);
      check("wake_drop", 32'h0, {pin_oe[wk], pin_out[wk]});
      check("reattach", 32'h1, pull_en);
    end
    $display("detach test done");
    wr(A_PSEL, 32'h00005432);
    wr(A_CTRL, cw(1'h1, 1'h0, 1'h0, 1'h0));
    w(60);
    check("busy_no_suspend", 32'h0, low_power);
    @(posedge hclk) traffic <= 1'h0;
    w(40);
    check("suspend", 32'h1, low_power);
    rc("status_suspend", A_STAT, 32'hD0, 32'h90);
    wr(A_CTRL, cw(1'h1, 1'h0, 1'h0, 1'h1));
    w(10);
    check("resume_k", 32'hE, {plus_oe, minus_oe, minus_out, plus_out});
    w(100);
    check("resume_end", 32'h0, {plus_oe, minus_oe});
    @(posedge hclk) traffic <= 1'h1;
    w(10);
    check("wake_by_host", 32'h0, low_power);
    $display("suspend test done");
    wr(A_CTRL, cw(1'h1, 1'h1, 1'h1, 1'h0));
    w(4);
    check("ext_pullup", 32'h3, {pull_en, pin_oe[5], pin_out[5]});
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      wr(A_PWR, v);
      rc("power", A_PWR, 32'hFFFFFFFF, {24'h000000, v[7:0]});
    end
    $display("register test done");
    summarize();
  end
endmodule // usb_attach_detach_control_test

// >>> tb/usb_host_model.sv
// host controller model that owns the far end of the usb data lines
`timescale 1ns/1ps
module usb_host_model (
  input wire logic hclk,
  input wire logic pull_up,
  input wire logic traffic,
  input wire logic plus_out,
  input wire logic plus_oe,
  input wire logic minus_out,
  input wire logic minus_oe,
  output logic plus_line,
  output logic minus_line
);
  // ------------------------------------------------------------
  // line levels seen by the device
  // ------------------------------------------------------------
  logic bit_ff = 1'h0;
  always @(posedge hclk) begin
    bit_ff <= ~bit_ff;
  end
  // pull-up gives idle J, else host pull-downs give SE0
  always_comb begin
    plus_line = pull_up;
    minus_line = 1'h0;
    // traffic changes every cycle so it never reads as a held idle level
    if (pull_up && traffic) begin
      plus_line = bit_ff;
      minus_line = ~bit_ff;
    end
    if (plus_oe) begin
      plus_line = plus_out;
    end
    if (minus_oe) begin
      minus_line = minus_out;
    end
  end
endmodule // usb_host_model
